// *** logic/fp_microword_sequencing_control.v ***
// Sequencing and host-handshake slice of a coprocessor microword, with an AXI4-Lite register slave.
// Assumes a control store that returns the word at microaddress in the same cycle, and a host
// that drives proceed_strobe and abort_request synchronous to aclk.
//
// What this block does
// - When bit 28 is set the condition register captures overflow, negative and zero of the exponent ALU.
// - When bit 27 is set the 4-bit counter loads from the selected source instead of counting.
// - The counter goes up by exactly one on each enabled clock and holds otherwise.
// - Bit 26 picks the load source: 0 the microword constant, 1 the prescale quotient.
// - The branch code in bits 25:21 with the pointer forms the next address, naming up to three conditions.
// - The null branch code takes the next address straight from the pointer.
// - When bit 20 is set sequencing stops until the host sends the proceed strobe.
// - When bit 19 is set the hold bit of the following microword is treated as clear.
// - When bit 18 is set the host may abort the running instruction, and only then.
// - When bit 17 is set a service request is raised toward the host.
// - When bit 16 is set an attention signal tells the host the device is ready to proceed.
// - The counter constant comes from microword bits 55:52.
// - The pointer sits in bits 8:0 as a 9-bit address that feeds the next-address logic.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fp_seq_map.vh"

module fp_microword_sequencing_control #(
	parameter              CNT_WIDTH     = 4,
	parameter [8:0]        ABORT_ADDRESS = `RST_ABORT_ADDR
) (
	input  wire                    aclk,
	input  wire                    aresetn,
	input  wire                    ce,
	input  wire [`AXI_ADDR_W-1:0]  s_axi_awaddr,
	input  wire [2:0]              s_axi_awprot,
	input  wire                    s_axi_awvalid,
	output reg                     s_axi_awready,
	input  wire [31:0]             s_axi_wdata,
	input  wire [3:0]              s_axi_wstrb,
	input  wire                    s_axi_wvalid,
	output reg                     s_axi_wready,
	output reg  [1:0]              s_axi_bresp,
	output reg                     s_axi_bvalid,
	input  wire                    s_axi_bready,
	input  wire [`AXI_ADDR_W-1:0]  s_axi_araddr,
	input  wire [2:0]              s_axi_arprot,
	input  wire                    s_axi_arvalid,
	output reg                     s_axi_arready,
	output reg  [31:0]             s_axi_rdata,
	output reg  [1:0]              s_axi_rresp,
	output reg                     s_axi_rvalid,
	input  wire                    s_axi_rready,
	input  wire [`UW_WIDTH-1:0]    microword,
	output reg  [8:0]              microaddress,
	input  wire                    exp_alu_overflow,
	input  wire                    exp_alu_negative,
	input  wire                    exp_alu_zero,
	input  wire [CNT_WIDTH-1:0]    prescale_quotient_source,
	input  wire                    counter_count_enable,
	input  wire [2:0]              branch_hits,
	input  wire                    proceed_strobe,
	input  wire                    abort_request,
	output reg                     abort_permit,
	output reg                     abort_taken,
	output reg  [2:0]              exp_alu_condition_register,
	output wire [CNT_WIDTH-1:0]    loop_count,
	output reg                     service_request,
	output reg                     attention_ready,
	output reg                     sequencer_held,
	output reg                     irq
);

	// ----------------------------------------------------------------
	// Current microinstruction and sequencing state
	// ----------------------------------------------------------------
	reg  [`UW_WIDTH-1:0]  ir;
	reg                   hold_inhibit_next;
	reg                   run;
	reg                   soft_proceed;
	reg  [`IRQ_N-1:0]     irq_status;
	reg  [`IRQ_N-1:0]     irq_mask;

	wire                  cond_reg_clock_enable;
	wire                  counter_load_enable;
	wire                  counter_source_select;
	wire [4:0]            branch_condition_field;
	wire [8:0]            next_pointer_field;
	wire                  hold_effective;
	wire                  proceed;
	wire                  abort_take;
	wire                  advance;
	wire                  step;
	wire [8:0]            next_address;
	wire [CNT_WIDTH-1:0]  counter_constant_field;
	wire [CNT_WIDTH-1:0]  counter_load_value;
	wire [`UW_WIDTH-1:0]  next_ir;

	assign cond_reg_clock_enable  = ir[`UW_COND_CLK];
	assign counter_load_enable    = ir[`UW_CNT_LOAD];
	assign counter_source_select  = ir[`UW_CNT_SEL];
	assign counter_constant_field = ir[`UW_CNT_K_HI:`UW_CNT_K_LO];
	assign branch_condition_field = microword[`UW_BR_HI:`UW_BR_LO];
	assign next_pointer_field     = microword[`UW_PTR_HI:`UW_PTR_LO];

	// The hold bit of the executing word is ignored when the word before it asked so.
	assign hold_effective = ir[`UW_HOLD] & ~hold_inhibit_next;
	assign proceed        = proceed_strobe | soft_proceed;
	// An abort from the host is honoured only while the executing word permits it.
	assign abort_take     = run & abort_request & ir[`UW_ABORT_OK];
	assign advance        = run & (~hold_effective | proceed);
	assign step           = advance | abort_take;
	// An abort replaces the prefetched word by an all-zero word, which has no side effects.
	assign next_ir        = abort_take ? {`UW_WIDTH{1'b0}} : microword;

	assign counter_load_value = counter_source_select ? prescale_quotient_source
		: counter_constant_field;

	next_address_logic u_next_address (
		.branch_code   (branch_condition_field),
		.pointer       (next_pointer_field),
		.branch_hits   (branch_hits),
		.abort_take    (abort_take),
		.abort_address (ABORT_ADDRESS),
		.next_address  (next_address)
	);

	loop_counter #(
		.WIDTH (CNT_WIDTH)
	) u_loop_counter (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.load       (step & counter_load_enable),
		.count      (counter_count_enable),
		.load_value (counter_load_value),
		.value      (loop_count)
	);

	// ----------------------------------------------------------------
	// Microsequencer
	// ----------------------------------------------------------------
	// The condition capture and counter load of a word land on the edge that retires it, so a held word acts once.
	always @(posedge aclk) begin
		if (!aresetn) begin
			ir                         <= {`UW_WIDTH{1'b0}};
			hold_inhibit_next          <= 1'b0;
			microaddress               <= `RST_ADDR;
			exp_alu_condition_register <= `RST_COND;
			service_request            <= 1'b0;
			attention_ready            <= 1'b0;
			abort_permit               <= 1'b0;
			abort_taken                <= 1'b0;
			sequencer_held             <= 1'b0;
		end else if (ce) begin
			abort_taken <= abort_take;
			if (step) begin
				ir                <= next_ir;
				hold_inhibit_next <= ir[`UW_HOLD_INH] & ~abort_take;
				microaddress      <= next_address;
				if (cond_reg_clock_enable) begin
					exp_alu_condition_register <= {exp_alu_overflow, exp_alu_negative,
						exp_alu_zero};
				end
				service_request <= next_ir[`UW_SERVICE];
				attention_ready <= next_ir[`UW_ATTN];
				abort_permit    <= next_ir[`UW_ABORT_OK];
				sequencer_held  <= next_ir[`UW_HOLD] & ~(ir[`UW_HOLD_INH] & ~abort_take);
			end else if (!run) begin
				sequencer_held <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register bus: write channel
	// ----------------------------------------------------------------
	reg                    aw_held;
	reg                    w_held;
	reg [`AXI_ADDR_W-1:0]  aw_addr;
	reg [31:0]             w_data;
	reg [3:0]              w_strb;
	reg                    rd_clear;

	wire                   wr_do;
	wire                   wr_hit;

	assign wr_do  = aw_held & w_held & ~s_axi_bvalid;
	assign wr_hit = (aw_addr == `REG_CTRL) | (aw_addr == `REG_STATUS)
		| (aw_addr == `REG_IRQ_STATUS) | (aw_addr == `REG_IRQ_MASK);

	// Address and data are taken in either order; the response waits for both.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= {`AXI_ADDR_W{1'b0}};
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			run           <= 1'b0;
			soft_proceed  <= 1'b0;
			irq_mask      <= `RST_IRQ;
		end else if (ce) begin
			soft_proceed <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
				if (w_strb[0]) begin
					if (aw_addr == `REG_CTRL) begin
						run          <= w_data[`CTRL_RUN];
						soft_proceed <= w_data[`CTRL_PROCEED];
					end
					if (aw_addr == `REG_IRQ_MASK) begin
						irq_mask <= w_data[`IRQ_N-1:0];
					end
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register bus: read channel
	// ----------------------------------------------------------------
	reg [31:0]  rd_mux;
	reg         rd_hit;

	always @* begin
		rd_mux = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`REG_CTRL: begin
				rd_mux[`CTRL_RUN] = run;
			end
			`REG_STATUS: begin
				rd_mux[`ST_ADDR_HI:0]                    = microaddress;
				rd_mux[`ST_HELD]                         = sequencer_held;
				rd_mux[`ST_ABORT_OK]                     = abort_permit;
				rd_mux[`ST_CNT_LO+CNT_WIDTH-1:`ST_CNT_LO] = loop_count;
				rd_mux[`ST_COND_LO+2:`ST_COND_LO]        = exp_alu_condition_register;
			end
			`REG_IRQ_STATUS: begin
				rd_mux[`IRQ_N-1:0] = irq_status;
			end
			`REG_IRQ_MASK: begin
				rd_mux[`IRQ_N-1:0] = irq_mask;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
			rd_clear      <= 1'b0;
		end else if (ce) begin
			rd_clear <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
				rd_clear      <= (s_axi_araddr == `REG_IRQ_STATUS);
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// Only the bits that the read returned are cleared, one cycle later while the data still
	// stands, so an event in the clearing cycle, or in the read cycle on a bit the read did not return, survives to the next read.
	wire [`IRQ_N-1:0]  irq_event;
	wire [`IRQ_N-1:0]  next_irq_status;

	assign irq_event[`IRQ_HOLD]          = step & sequencer_held_next_bit(next_ir, ir, abort_take);
	assign irq_event[`IRQ_SERVICE]       = step & next_ir[`UW_SERVICE];
	assign irq_event[`IRQ_ATTN]          = step & next_ir[`UW_ATTN];
	assign irq_event[`IRQ_ABORT]         = abort_take;
	assign irq_event[`IRQ_ABORT_REFUSED] = run & abort_request & ~ir[`UW_ABORT_OK];
	assign next_irq_status = (irq_status & ~(rd_clear ? s_axi_rdata[`IRQ_N-1:0] : {`IRQ_N{1'b0}})) | irq_event;

	function sequencer_held_next_bit;
		input [`UW_WIDTH-1:0] word;
		input [`UW_WIDTH-1:0] cur;
		input                 aborting;
		begin
			sequencer_held_next_bit = word[`UW_HOLD] & ~(cur[`UW_HOLD_INH] & ~aborting);
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= `RST_IRQ;
			irq        <= 1'b0;
		end else if (ce) begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_mask);
		end
	end

endmodule
`default_nettype wire

// *** logic/fp_seq_map.vh ***
// Field positions, register map and reset values of the microword sequencing slice.
// Assumes it is included by its bare name from files that use the macros below.
`ifndef FP_SEQ_MAP_VH
`define FP_SEQ_MAP_VH

// ----------------------------------------------------------------
// Microword field positions
// ----------------------------------------------------------------
`define UW_COND_CLK       28
`define UW_CNT_LOAD       27
`define UW_CNT_SEL        26
`define UW_BR_HI          25
`define UW_BR_LO          21
`define UW_HOLD           20
`define UW_HOLD_INH       19
`define UW_ABORT_OK       18
`define UW_SERVICE        17
`define UW_ATTN           16
`define UW_CNT_K_HI       55
`define UW_CNT_K_LO       52
`define UW_PTR_HI         8
`define UW_PTR_LO         0
`define UW_WIDTH          64
`define BR_NULL           5'h00

// ----------------------------------------------------------------
// Register map (byte addresses) and field positions
// ----------------------------------------------------------------
`define AXI_ADDR_W        8
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_STATUS    8'h08
`define REG_IRQ_MASK      8'h0C
`define CTRL_RUN          0
`define CTRL_PROCEED      1
`define ST_ADDR_HI        8
`define ST_HELD           9
`define ST_ABORT_OK       10
`define ST_CNT_LO         12
`define ST_COND_LO        16
`define IRQ_N             5
`define IRQ_HOLD          0
`define IRQ_SERVICE       1
`define IRQ_ATTN          2
`define IRQ_ABORT         3
`define IRQ_ABORT_REFUSED 4
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ADDR          9'h000
`define RST_ABORT_ADDR    9'h000
`define RST_COUNT         4'h0
`define RST_COND          3'h0
`define RST_IRQ           5'h00

`endif

// *** logic/loop_counter.v ***
// Loadable up-counter used as the microcode loop counter.
// Assumes load and count are qualified by the caller; ce freezes the count.
`timescale 1ns/1ps
`default_nettype none
`include "fp_seq_map.vh"

module loop_counter #(
	parameter WIDTH = 4
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             ce,
	input  wire             load,
	input  wire             count,
	input  wire [WIDTH-1:0] load_value,
	output reg  [WIDTH-1:0] value
);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// A load in the same cycle as a count wins, so the loop starts from the load value.
	always @(posedge aclk) begin
		if (!aresetn) begin
			value <= `RST_COUNT;
		end else if (ce) begin
			if (load) begin
				value <= load_value;
			end else if (count) begin
				value <= value + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule
`default_nettype wire

// *** logic/next_address_logic.v ***
// Combinational next-microaddress selection from pointer, branch code and abort.
// Assumes branch_hits already holds the conditions named by branch_code, masked outside.
`timescale 1ns/1ps
`default_nettype none
`include "fp_seq_map.vh"

module next_address_logic (
	input  wire [4:0] branch_code,
	input  wire [8:0] pointer,
	input  wire [2:0] branch_hits,
	input  wire       abort_take,
	input  wire [8:0] abort_address,
	output reg  [8:0] next_address
);

	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	// Each true condition sets one low address bit, so up to three conditions fan out to eight targets.
	always @* begin
		if (abort_take) begin
			next_address = abort_address;
		end else if (branch_code == `BR_NULL) begin
			next_address = pointer;
		end else begin
			next_address = {pointer[8:3], pointer[2:0] | branch_hits};
		end
	end

endmodule
`default_nettype wire

// *** bench/fp_seq_assertions.sv ***
// Concurrent checks on the sequencing ports of the microword control block.
// Assumes a same-cycle control store and test programs whose steps always change the address.
`timescale 1ns/1ps
`default_nettype none

module fp_seq_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	input wire logic [63:0] microword,
	input wire logic [8:0]  microaddress,
	input wire logic [2:0]  branch_hits,
	input wire logic        proceed_strobe,
	input wire logic        abort_request,
	input wire logic        abort_permit,
	input wire logic        abort_taken,
	input wire logic [2:0]  exp_alu_condition_register,
	input wire logic        service_request,
	input wire logic        attention_ready,
	input wire logic        sequencer_held,
	input wire logic        s_axi_bvalid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// An abort also moves the address, so steps that may be aborts are left out.
	sequence s_step;
		$changed(microaddress) && !$past(abort_request);
	endsequence
	// A register proceed acts at the edge where the write response stands, so those cycles are left out.
	sequence s_held_idle;
		sequencer_held && ce && !proceed_strobe && !abort_request && !s_axi_bvalid;
	endsequence

	chk_null_branch: assert property (s_step ##0 $past(microword[25:21]) == 5'h00
		|-> microaddress == $past(microword[8:0])) else $error("next address is not the pointer");
	chk_branch_or: assert property (s_step ##0 $past(microword[25:21]) != 5'h00
		|-> microaddress == {$past(microword[8:3]), $past(microword[2:0]) | $past(branch_hits)})
		else $error("branch address wrong");
	chk_service_word: assert property (s_step |-> service_request == $past(microword[17]))
		else $error("service request does not follow word");
	chk_attn_word: assert property (s_step |-> attention_ready == $past(microword[16]))
		else $error("attention does not follow word");
	chk_req_steady: assert property ($stable(microaddress) |-> $stable({service_request, attention_ready}))
		else $error("request moved between steps");
	chk_hold_freeze: assert property (s_held_idle |=> $stable(microaddress))
		else $error("held sequencer advanced");
	chk_abort_gate: assert property ($rose(abort_taken) |-> ($past(abort_request) && $past(abort_permit))
		|| ($past(abort_request, 2) && $past(abort_permit, 2))) else $error("abort taken without permission");
	chk_abort_pulse: assert property (abort_taken |=> !abort_taken)
		else $error("abort pulse too long");
	chk_cond_steady: assert property ($changed(exp_alu_condition_register) |-> $changed(microaddress))
		else $error("condition register moved without a step");
endmodule

bind fp_microword_sequencing_control fp_seq_assertions i_chk (.aclk, .aresetn, .ce, .microword, .microaddress,
	.branch_hits, .proceed_strobe, .abort_request, .abort_permit, .abort_taken, .exp_alu_condition_register,
	.service_request, .attention_ready, .sequencer_held, .s_axi_bvalid);

`default_nettype wire

// *** bench/host_partner.sv ***
// Behavioural host that releases holds and requests aborts when the bench commands it.
// Assumes the bench changes the command lines by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module host_partner (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic cmd_go,
	input  wire logic cmd_abort,
	input  wire logic cmd_rogue,
	input  wire logic attention_ready,
	input  wire logic abort_permit,
	input  wire logic abort_taken,
	output var  logic proceed_strobe,
	output var  logic abort_request,
	output var  logic awake
);
	logic go_d;
	logic abort_want;
	logic rogue_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			go_d           <= 1'b0;
			proceed_strobe <= 1'b0;
			abort_want     <= 1'b0;
			rogue_q        <= 1'b0;
			awake          <= 1'b0;
		end else begin
			go_d           <= cmd_go;
			proceed_strobe <= cmd_go && !go_d;
			abort_want     <= cmd_abort;
			rogue_q        <= cmd_rogue;
			if (attention_ready)
				awake <= 1'b1;
		end
	end

	// Gated by the registered permit itself, so the request falls in the cycle the permit does.
	// The rogue command ignores permission, so that refusal can be exercised.
	always_comb begin
		abort_request = rogue_q || (abort_want && abort_permit && !abort_taken);
	end
endmodule

`default_nettype wire

// *** bench/fp_microword_sequencing_control_bench.sv ***
// Self-checking bench: AXI4-Lite register tasks and a small microprogram in a same-cycle control store.
// Assumes the design header is on the include path and the partner and checker compile first.
`timescale 1ns/1ps
`default_nettype none
`include "fp_seq_map.vh"

module fp_microword_sequencing_control_bench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, alu = 3'h5, branch_hits = 3'h5;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF, prescale_quotient_source = 4'h5;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, counter_count_enable = 1'b0;
	logic        cmd_go = 1'b0, cmd_abort = 1'b0, cmd_rogue = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         proceed_strobe, abort_request, abort_permit, abort_taken;
	wire         service_request, attention_ready, sequencer_held, irq, awake;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [8:0]   microaddress;
	wire [2:0]   exp_alu_condition_register;
	wire [3:0]   loop_count;
	wire [63:0]  microword;
	logic [63:0] rom [0:511];
	int          err_total = 0, checked = 0, cyc = 0, n = 0;

	assign microword = rom[microaddress];

	fp_microword_sequencing_control i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .microword, .microaddress, .exp_alu_overflow(alu[2]),
		.exp_alu_negative(alu[1]), .exp_alu_zero(alu[0]), .prescale_quotient_source, .counter_count_enable,
		.branch_hits, .proceed_strobe, .abort_request, .abort_permit, .abort_taken, .exp_alu_condition_register,
		.loop_count, .service_request, .attention_ready, .sequencer_held, .irq);

	host_partner i_host (.aclk, .aresetn, .cmd_go, .cmd_abort, .cmd_rogue, .attention_ready, .abort_permit,
		.abort_taken, .proceed_strobe, .abort_request, .awake);

	always #10 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			err_total = err_total + 1;
			$display("ERROR %0t run did not finish", $time);
			conclude;
		end
	end

	task conclude;
		begin
			$display("comparisons %0d mismatches %0d", checked, err_total);
			if (err_total == 0 && checked > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
			end
		end
	endtask

	// One AXI4-Lite transfer; for a read, d is the expected data.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		begin
			@(posedge aclk);
			if (w) begin
				s_axi_awaddr <= a;
				s_axi_wdata <= d;
				s_axi_awvalid <= 1'b1;
				s_axi_wvalid <= 1'b1;
				s_axi_bready <= 1'b1;
			end else begin
				s_axi_araddr <= a;
				s_axi_arvalid <= 1'b1;
				s_axi_rready <= 1'b1;
			end
			// Only the bench timeout ends this wait.
			do begin
				@(posedge aclk);
				if (s_axi_awvalid && s_axi_awready)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wvalid && s_axi_wready)
					s_axi_wvalid <= 1'b0;
				if (s_axi_arvalid && s_axi_arready)
					s_axi_arvalid <= 1'b0;
			end while (!(w ? s_axi_bvalid : s_axi_rvalid));
			s_axi_bready <= 1'b0;
			s_axi_rready <= 1'b0;
			cmp(w ? 32'(s_axi_bresp) : 32'(s_axi_rresp), 32'(er), "response");
			if (!w)
				cmp(s_axi_rdata, d, "read data");
		end
	endtask

	task at(input logic [8:0] a);
		integer k;
		begin
			k = 0;
			do begin
				@(negedge aclk);
				k = k + 1;
			end while (microaddress !== a && k < 200);
			cmp(32'(microaddress), 32'(a), "address");
		end
	endtask

	task go;
		begin
			@(posedge aclk);
			cmd_go <= 1'b1;
			@(posedge aclk);
			cmd_go <= 1'b0;
		end
	endtask

	initial begin
		for (int i = 0; i < 512; i++)
			rom[i] = 64'h0;
		rom[0] = 64'h00A0_0000_1812_0001;
		rom[1] = 64'h0000_0000_0019_0002;
		rom[2] = 64'h00F0_0000_0C14_0003;
		rom[3] = 64'h0000_0000_0030_0010;
		rom[21] = 64'h0000_0000_0014_0016;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		xfer(0, `REG_CTRL, 32'h0, `RESP_OKAY);
		xfer(0, `REG_STATUS, 32'h0, `RESP_OKAY);
		xfer(0, `REG_IRQ_STATUS, 32'h0, `RESP_OKAY);
		xfer(0, `REG_IRQ_MASK, 32'h0, `RESP_OKAY);
		xfer(1, `REG_STATUS, 32'hFFFF_FFFF, `RESP_OKAY);
		xfer(0, `REG_STATUS, 32'h0, `RESP_OKAY);
		xfer(1, 8'h10, 32'h1, `RESP_SLVERR);
		xfer(0, 8'h10, 32'h0, `RESP_SLVERR);
		$display("register test done");
		xfer(1, `REG_CTRL, 32'h1, `RESP_OKAY);
		at(9'h001);
		cmp(32'(service_request), 32'h1, "service");
		cmp(32'(attention_ready), 32'h0, "attention");
		cmp(32'(irq), 32'h0, "masked irq");
		repeat (4) @(negedge aclk);
		cmp(32'(microaddress), 32'h1, "held address");
		go;
		at(9'h002);
		cmp(32'(loop_count), 32'hA, "loaded count");
		cmp(32'(exp_alu_condition_register), 32'h5, "condition");
		cmp(32'(attention_ready), 32'h1, "attention");
		cmp(32'(service_request), 32'h0, "service cleared");
		@(posedge aclk);
		alu <= 3'h2;
		repeat (2) @(negedge aclk);
		cmp(32'(exp_alu_condition_register), 32'h5, "condition held");
		cmp(32'(awake), 32'h1, "host awake");
		go;
		at(9'h015);
		cmp(32'(loop_count), 32'h5, "quotient load");
		@(posedge aclk);
		counter_count_enable <= 1'b1;
		repeat (3) @(posedge aclk);
		counter_count_enable <= 1'b0;
		repeat (3) @(negedge aclk);
		cmp(32'(loop_count), 32'h8, "count");
		$display("sequencing test done");
		xfer(1, `REG_IRQ_MASK, 32'h10, `RESP_OKAY);
		xfer(0, `REG_IRQ_MASK, 32'h10, `RESP_OKAY);
		cmp(32'(irq), 32'h0, "irq masked");
		@(posedge aclk);
		cmd_rogue <= 1'b1;
		repeat (3) @(posedge aclk);
		cmd_rogue <= 1'b0;
		repeat (2) @(negedge aclk);
		cmp(32'(microaddress), 32'h15, "refused abort");
		cmp(32'(irq), 32'h1, "irq raised");
		xfer(0, `REG_IRQ_STATUS, 32'h17, `RESP_OKAY);
		@(negedge aclk);
		cmp(32'(irq), 32'h0, "irq cleared");
		xfer(0, `REG_IRQ_STATUS, 32'h0, `RESP_OKAY);
		$display("interrupt test done");
		go;
		at(9'h016);
		cmp(32'(abort_permit), 32'h1, "permit");
		@(posedge aclk);
		cmd_abort <= 1'b1;
		do begin
			@(negedge aclk);
			n = n + 1;
		end while (abort_taken !== 1'b1 && n < 50);
		cmp(32'(abort_taken), 32'h1, "abort taken");
		@(posedge aclk);
		cmd_abort <= 1'b0;
		at(9'h001);
		cmp(32'(sequencer_held), 32'h1, "restart after abort");
		xfer(1, `REG_CTRL, 32'h3, `RESP_OKAY);
		at(9'h002);
		cmp(32'(sequencer_held), 32'h1, "register proceed");
		xfer(1, `REG_CTRL, 32'h0, `RESP_OKAY);
		$display("abort test done");
		conclude;
	end
endmodule

`default_nettype wire
